// ==== logic/rsmd_top.sv ====
// rsmd_top: rs-485 direction output control and 9-bit multidrop receive handling
// assumes the uart supplies register bits as levels and character/tx events as pulses
//
// Contract
// - with auto direction off the direction pin follows the inverse of modem-control bit 1, or flow control when enabled.
// - extra-features bit 4 gives the direction pin to the transmitter, overriding both other sources.
// - in auto direction mode the pin goes low on a transmit fifo write and high after the last bit.
// - extra-features bit 5 inverts the auto direction polarity.
// - extra-features bit 0 enables 9-bit mode where a ninth bit of 1 marks an address.
// - in managed multidrop with receiver off, data bytes are dropped until software clears the receiver-off bit.
// - a managed-mode address byte is stored with parity error and a line-status interrupt if enabled.
// - an enabled receiver takes data until disabled and flags each later address byte.
// - with special detect on and receiver off, data and unmatched address bytes are dropped.
// - a matching address enables the receiver, is stored with its ninth bit as parity error and interrupts if enabled.
// - while enabled, an unmatched address disables and is dropped, a match is stored with flag.
// - the receiver-off bit halts reception at once and is the enable multidrop handling sets and clears.
module rsmd_top
  import rsmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] extra_features_control_reg_i,
  input wire logic [7:0] enhanced_features_reg_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic [7:0] interrupt_enable_reg_i,
  input wire logic [7:0] line_format_reg_i,
  input wire logic [7:0] second_stop_char_reg_i,
  input wire logic flow_ctl_en_i,
  input wire logic flow_ctl_rts_i,
  input wire logic rx_off_wr_i,
  input wire logic rx_off_wdata_i,
  input wire logic tx_fifo_wr_i,
  input wire logic tx_done_i,
  input wire logic tx_empty_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ninth_i,
  output logic rts_o,
  output logic receiver_off_bit_o,
  output logic rx_push_o,
  output logic [7:0] rx_push_data_o,
  output logic rx_par_err_o,
  output logic line_stat_irq_o
);
  // ==========================================================
  // direction control
  rsmd_dir_t dir_q, dir_d;
  logic auto_dir, inv;
  assign auto_dir = extra_features_control_reg_i[EFC_AUTO_DIR];
  assign inv = extra_features_control_reg_i[EFC_DIR_INV];
  always_comb begin
    dir_d = dir_q;
    case (dir_q)
      RSMD_IDLE: if (tx_fifo_wr_i) dir_d = RSMD_BUSY;
      RSMD_BUSY: if (tx_done_i && tx_empty_i && !tx_fifo_wr_i) dir_d = RSMD_IDLE;
      RSMD_DRAIN: dir_d = RSMD_IDLE;
      default: dir_d = RSMD_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) dir_q <= RSMD_IDLE;
    else dir_q <= dir_d;
  end
  logic rts_d, rts_q;
  always_comb begin
    if (auto_dir) begin
      rts_d = (dir_q == RSMD_BUSY) ? inv : !inv;
    end else if (flow_ctl_en_i) begin
      rts_d = flow_ctl_rts_i;
    end else begin
      rts_d = !modem_control_reg_i[MCTL_RTS];
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rts_q <= RTS_IDLE;
    else rts_q <= rts_d;
  end
  // registered pin: no glitch while sources switch, at the cost of one cycle of lag
  assign rts_o = rts_q;

  // ==========================================================
  // multidrop receive
  // receiver enable is held here since hardware sets and clears it; software writes win
  // only when no auto-mode address character arrives in the same cycle
  rsmd_rx_if rxi ();
  assign rxi.valid = rx_valid_i;
  assign rxi.data = rx_data_i;
  assign rxi.ninth = rx_ninth_i;
  logic nine_bit, special, rx_en_q, rx_en_d;
  assign nine_bit = extra_features_control_reg_i[EFC_NINE_BIT];
  assign special = enhanced_features_reg_i[EFE_SPECIAL];
  rsmd_addr_filter u_filter (
    .rx(rxi.flt),
    .nine_bit_i(nine_bit),
    .special_i(special),
    .rx_en_i(rx_en_q),
    .match_char_i(second_stop_char_reg_i)
  );
  logic auto_mode;
  assign auto_mode = nine_bit && special;
  always_comb begin
    rx_en_d = rx_en_q;
    if (rx_off_wr_i) rx_en_d = !rx_off_wdata_i;
    if (rx_valid_i && auto_mode && rx_ninth_i) begin
      rx_en_d = rxi.keep;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rx_en_q <= RX_EN_RESET;
    else rx_en_q <= rx_en_d;
  end
  assign receiver_off_bit_o = !rx_en_q;
  logic push_d, push_q, perr_d, perr_q, irq_d, irq_q;
  logic [7:0] pdata_d, pdata_q;
  always_comb begin
    push_d = rx_valid_i && rxi.keep;
    perr_d = push_d && rxi.flag;
    irq_d = perr_d && interrupt_enable_reg_i[IEN_LINE_STAT];
    pdata_d = push_d ? rx_data_i : pdata_q;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      push_q <= 1'b0;
      perr_q <= 1'b0;
      irq_q <= 1'b0;
      pdata_q <= 8'h00;
    end else begin
      push_q <= push_d;
      perr_q <= perr_d;
      irq_q <= irq_d;
      pdata_q <= pdata_d;
    end
  end
  assign rx_push_o = push_q;
  assign rx_push_data_o = pdata_q;
  assign rx_par_err_o = perr_q;
  assign line_stat_irq_o = irq_q;

  // ==========================================================
  // direction checks
  a_auto_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    auto_dir && !inv && dir_q == RSMD_BUSY |=> !rts_o)
    else $error("rts not low");
  a_inv_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    auto_dir && inv && dir_q == RSMD_BUSY |=> rts_o)
    else $error("inv rts not high");
  a_wr_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_fifo_wr_i |=> dir_q == RSMD_BUSY)
    else $error("write did not start");
  // release shows two edges after the last bit: state first, then the pin register
  a_done_high: assert property (@(posedge clk_i) disable iff (!resetn_i)
    auto_dir && !inv && dir_q == RSMD_BUSY && tx_done_i && tx_empty_i && !tx_fifo_wr_i
    |=> ##1 rts_o)
    else $error("rts not released");
  a_done_inv: assert property (@(posedge clk_i) disable iff (!resetn_i)
    auto_dir && inv && dir_q == RSMD_BUSY && tx_done_i && tx_empty_i && !tx_fifo_wr_i
    |=> ##1 !rts_o)
    else $error("inverted rts not released");
  a_modem_src: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !auto_dir && !flow_ctl_en_i |=> rts_o == !$past(modem_control_reg_i[MCTL_RTS]))
    else $error("modem source wrong");
  a_flow_src: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !auto_dir && flow_ctl_en_i |=> rts_o == $past(flow_ctl_rts_i))
    else $error("flow source wrong");

  // ==========================================================
  // receive checks
  a_drop_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && nine_bit && !special && !rx_ninth_i && !rx_en_q |=> !rx_push_o)
    else $error("data not dropped");
  a_mgd_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && nine_bit && !special && !rx_ninth_i && rx_en_q |=> rx_push_o && !rx_par_err_o)
    else $error("managed data not kept");
  a_addr_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && nine_bit && !special && rx_ninth_i |=> rx_push_o && rx_par_err_o)
    else $error("address not flagged");
  a_match_en: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && auto_mode && rx_ninth_i && rx_data_i == second_stop_char_reg_i
    |=> rx_en_q && rx_push_o)
    else $error("match not taken");
  a_miss_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && auto_mode && rx_ninth_i && rx_data_i != second_stop_char_reg_i
    |=> !rx_en_q && !rx_push_o)
    else $error("miss not dropped");
  a_auto_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && auto_mode && !rx_ninth_i && !rx_en_q |=> !rx_push_o)
    else $error("data kept");
  a_auto_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && auto_mode && !rx_ninth_i && rx_en_q |=> rx_push_o && !rx_par_err_o)
    else $error("auto data not kept");
  a_norm_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && !nine_bit && rx_en_q |=> rx_push_o && !rx_par_err_o)
    else $error("normal char not kept");
  a_norm_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_valid_i && !nine_bit && !rx_en_q |=> !rx_push_o)
    else $error("char kept while off");
  // an auto-mode address arriving with the write overrides it, so it is left out here
  a_off_halt: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_off_wr_i && rx_off_wdata_i && !(rx_valid_i && auto_mode && rx_ninth_i) |=> receiver_off_bit_o)
    else $error("receiver not halted");
  a_on_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_off_wr_i && !rx_off_wdata_i && !(rx_valid_i && auto_mode && rx_ninth_i) |=> !receiver_off_bit_o)
    else $error("receiver not enabled");
  a_push_data: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_push_o |-> rx_push_data_o == $past(rx_data_i))
    else $error("pushed byte wrong");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    line_stat_irq_o |-> rx_par_err_o)
    else $error("irq without flag");
  a_irq_en: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_par_err_o && $past(interrupt_enable_reg_i[IEN_LINE_STAT]) |-> line_stat_irq_o)
    else $error("enabled irq missing");

  // ==========================================================
  // coverage
  c_auto_frame: cover property (@(posedge clk_i) disable iff (!resetn_i)
    auto_dir && tx_fifo_wr_i ##[1:50] rts_o);
  c_addr_match: cover property (@(posedge clk_i) disable iff (!resetn_i)
    auto_mode && rx_push_o && rx_par_err_o);
  c_managed_addr: cover property (@(posedge clk_i) disable iff (!resetn_i)
    nine_bit && !special && line_format_reg_i[LFMT_PAR_LSB +: 3] == LFMT_FORCE0 && line_stat_irq_o);
  c_auto_data: cover property (@(posedge clk_i) disable iff (!resetn_i)
    auto_mode && rx_push_o && !rx_par_err_o);
endmodule : rsmd_top

// ==== logic/rsmd_pkg.sv ====
// rs-485 direction control and multidrop receive filter: shared constants and types
// assumes one clock domain, registers held by the surrounding uart except the receiver-off bit
package rsmd_pkg;
  // extra-features control bits
  localparam int unsigned EFC_NINE_BIT = 0;
  localparam int unsigned EFC_RX_OFF = 1;
  localparam int unsigned EFC_AUTO_DIR = 4;
  localparam int unsigned EFC_DIR_INV = 5;
  // enhanced-features bit: special character detect
  localparam int unsigned EFE_SPECIAL = 5;
  // interrupt-enable bit for line status
  localparam int unsigned IEN_LINE_STAT = 2;
  // modem-control bit driving the direction output
  localparam int unsigned MCTL_RTS = 1;
  // line-format parity field and forced-zero code
  localparam int unsigned LFMT_PAR_LSB = 3;
  localparam logic [2:0] LFMT_FORCE0 = 3'h7;
  // line-status parity error position
  localparam int unsigned LSTAT_PAR_ERR = 2;
  // reset values
  localparam logic RTS_IDLE = 1'b1;
  localparam logic RX_EN_RESET = 1'b0;
  typedef enum logic [2:0] {
    RSMD_IDLE = 3'b001,
    RSMD_BUSY = 3'b010,
    RSMD_DRAIN = 3'b100
  } rsmd_dir_t;
endpackage : rsmd_pkg

// ==== logic/rsmd_rx_if.sv ====
// rsmd_rx_if: carries one received 9-bit character from main module to the filter
// assumes a single clock, valid is a one-cycle pulse
interface rsmd_rx_if;
  logic valid;
  logic [7:0] data;
  logic ninth;
  logic keep;
  logic flag;
  modport src (output valid, output data, output ninth, input keep, input flag);
  modport flt (input valid, input data, input ninth, output keep, output flag);
endinterface : rsmd_rx_if

// ==== logic/rsmd_addr_filter.sv ====
// rsmd_addr_filter: decides keep/flag for a received character in multidrop modes
// assumes the caller qualifies the result with the character's valid pulse
module rsmd_addr_filter
  import rsmd_pkg::*;
(
  rsmd_rx_if.flt rx,
  input wire logic nine_bit_i,
  input wire logic special_i,
  input wire logic rx_en_i,
  input wire logic [7:0] match_char_i
);
  logic hit;
  always_comb begin
    hit = rx.ninth && (rx.data == match_char_i);
    rx.keep = 1'b1;
    rx.flag = 1'b0;
    if (nine_bit_i && special_i) begin
      // an enabled receiver still takes data bytes; only addresses go through the match
      rx.keep = rx.ninth ? hit : rx_en_i;
      rx.flag = hit && rx.ninth;
    end else if (nine_bit_i) begin
      rx.keep = rx.ninth || rx_en_i;
      rx.flag = rx.ninth;
    end else begin
      rx.keep = rx_en_i;
    end
  end
endmodule : rsmd_addr_filter

// ==== test/rsmd_station_model.sv ====
// rsmd_station_model: remote multidrop stations seen through the rs-485 transceiver
// assumes one clock; each character reaches the uart as a one-cycle valid pulse
module rsmd_station_model (
  input wire logic clk_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic ninth_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // character source
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    ninth_o = 1'b0;
  end
  // ninth bit 1 marks an address character, 0 a data character
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge clk_i);
    #2;
    valid_o = 1'b1;
    data_o = d;
    ninth_o = n;
    @(posedge clk_i);
    #2;
    valid_o = 1'b0;
    // released lines show the inverse so a stale byte cannot pass as a match
    data_o = ~d;
    ninth_o = ~n;
  endtask
endmodule // rsmd_station_model

// ==== test/tb.sv ====
// tb: self-checking bench for rs-485 direction control and multidrop receive
// assumes 20 mhz clock; register bits are plain levels set by the bench
module tb import rsmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // stimulus and wiring
  logic clk_i = 1'b0, resetn_i = 1'b0, fc_en = 1'b0, fc_rts = 1'b0, off_wr = 1'b0, off_wd = 1'b0;
  logic tx_wr = 1'b0, tx_done = 1'b0, tx_empty = 1'b1, rts, rx_off, push, perr, irq;
  logic rx_valid, rx_ninth;
  logic [7:0] efc = 8'h00, efe = 8'h00, mctl = 8'h00, ien = 8'h00, stop_char = 8'h5a;
  logic [7:0] lfmt = 8'h38, rx_data, pdata;
  int err_total = 0, total_checks = 0;
  always #25 clk_i = ~clk_i;
  rsmd_station_model i_stn (.clk_i(clk_i), .valid_o(rx_valid), .data_o(rx_data),
    .ninth_o(rx_ninth));
  rsmd_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .extra_features_control_reg_i(efc),
    .enhanced_features_reg_i(efe), .modem_control_reg_i(mctl), .interrupt_enable_reg_i(ien),
    .line_format_reg_i(lfmt), .second_stop_char_reg_i(stop_char), .flow_ctl_en_i(fc_en),
    .flow_ctl_rts_i(fc_rts), .rx_off_wr_i(off_wr), .rx_off_wdata_i(off_wd),
    .tx_fifo_wr_i(tx_wr), .tx_done_i(tx_done), .tx_empty_i(tx_empty), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ninth_i(rx_ninth), .rts_o(rts), .receiver_off_bit_o(rx_off),
    .rx_push_o(push), .rx_push_data_o(pdata), .rx_par_err_o(perr), .line_stat_irq_o(irq));
  // ==========================================================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rts_chk(input logic e);
    chk({7'h00, rts}, {7'h00, e}, "direction pin");
  endtask
  // one character in; push, flag, irq and receiver state checked the cycle after
  task automatic rx(input logic [7:0] d, input logic n, input logic ep, input logic ee,
    input logic eoff);
    i_stn.send(d, n);
    chk({7'h00, push}, {7'h00, ep}, "push");
    if (ep) begin
      chk(pdata, d, "pushed byte");
      chk({7'h00, perr}, {7'h00, ee}, "parity flag");
    end
    chk({7'h00, irq}, {7'h00, ep & ee & ien[IEN_LINE_STAT]}, "line status irq");
    chk({7'h00, rx_off}, {7'h00, eoff}, "receiver off");
  endtask
  task automatic set_off(input logic v);
    off_wr = 1'b1;
    off_wd = v;
    step(1);
    off_wr = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // whole run is far below this bound; reaching it means a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  // ==========================================================================
  // scenarios
  initial begin
    step(2);
    resetn_i = 1'b1;
    rts_chk(RTS_IDLE);
    mctl[MCTL_RTS] = 1'b1;
    step(2);
    rts_chk(1'b0);
    fc_en = 1'b1;
    fc_rts = 1'b1;
    step(2);
    rts_chk(1'b1);
    efc[EFC_AUTO_DIR] = 1'b1;
    fc_rts = 1'b0;
    step(2);
    rts_chk(1'b1);
    fc_en = 1'b0;
    for (int inv = 0; inv < 2; inv++) begin
      efc[EFC_DIR_INV] = inv[0];
      step(3);
      rts_chk(~inv[0]);
      tx_wr = 1'b1;
      tx_empty = 1'b0;
      step(1);
      tx_wr = 1'b0;
      step(1);
      rts_chk(inv[0]);
      tx_done = 1'b1;
      tx_empty = 1'b1;
      step(1);
      tx_done = 1'b0;
      step(1);
      rts_chk(~inv[0]);
    end
    efc = 8'h00;
    step(2);
    rts_chk(1'b0);
    efc[EFC_NINE_BIT] = 1'b1;
    ien[IEN_LINE_STAT] = 1'b1;
    rx(8'h11, 1'b0, 1'b0, 1'b0, 1'b1);
    rx(8'h5a, 1'b1, 1'b1, 1'b1, 1'b1);
    set_off(1'b0);
    rx(8'h22, 1'b0, 1'b1, 1'b0, 1'b0);
    ien[IEN_LINE_STAT] = 1'b0;
    rx(8'h33, 1'b1, 1'b1, 1'b1, 1'b0);
    set_off(1'b1);
    rx(8'h44, 1'b0, 1'b0, 1'b0, 1'b1);
    efe[EFE_SPECIAL] = 1'b1;
    ien[IEN_LINE_STAT] = 1'b1;
    rx(8'h5a, 1'b0, 1'b0, 1'b0, 1'b1);
    rx(8'h5b, 1'b1, 1'b0, 1'b0, 1'b1);
    rx(8'hda, 1'b1, 1'b0, 1'b0, 1'b1);
    rx(8'h5a, 1'b1, 1'b1, 1'b1, 1'b0);
    rx(8'h66, 1'b0, 1'b1, 1'b0, 1'b0);
    rx(8'h5a, 1'b1, 1'b1, 1'b1, 1'b0);
    rx(8'h5e, 1'b1, 1'b0, 1'b0, 1'b1);
    rx(8'h77, 1'b0, 1'b0, 1'b0, 1'b1);
    efe = 8'h00;
    efc = 8'h00;
    set_off(1'b0);
    rx(8'h81, 1'b1, 1'b1, 1'b0, 1'b0);
    close_out();
  end
endmodule // tb
